/* design/pa_boost_fault_and_control.sv */
// Control register and fault supervision of the amplifier boost regulator
// How it works
// - Fault flag set at enable until output ready
// - Over-current: switch off, flag, cycle limiting
// - Current back below limit clears by itself
// - Short: regulator off, isolation off, flag set
// - Short latched until host re-enables
// - Short detection masked during soft start
// - Soft start ends after four milliseconds
// - Over-voltage shuts regulator, sets flag
// - Over-voltage latched until host re-enables
// - Standby exit copies bits 5:3 if valid
// - Register at 0x3B, reset 0x24
`include "pa_boost_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pa_boost_fault_and_control #(
    parameter int SOFT_START_CYCLES = `SOFT_START_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic standby_exit_pin,
    input wire logic over_current_in,
    input wire logic short_circuit_in,
    input wire logic over_voltage_in,
    input wire logic under_voltage_in,
    output logic regulator_enable,
    output logic switch_gate_enable,
    output logic isolation_switch,
    output logic boost_fault_flag,
    output logic select_5v0
);
    localparam logic [23:0] SS_LAST = 24'(SOFT_START_CYCLES - 1);

    // ---------------------------------
    // Pin synchronisers
    // ---------------------------------
    logic exit_lvl;
    logic oc_lvl;
    logic sc_lvl;
    logic ov_lvl;
    logic uv_lvl;
    pin_sync u_exit (.clk_sys(clk_sys), .rst_n(rst_n), .pin(standby_exit_pin), .level(exit_lvl));
    pin_sync u_oc (.clk_sys(clk_sys), .rst_n(rst_n), .pin(over_current_in), .level(oc_lvl));
    pin_sync u_sc (.clk_sys(clk_sys), .rst_n(rst_n), .pin(short_circuit_in), .level(sc_lvl));
    pin_sync u_ov (.clk_sys(clk_sys), .rst_n(rst_n), .pin(over_voltage_in), .level(ov_lvl));
    pin_sync u_uv (.clk_sys(clk_sys), .rst_n(rst_n), .pin(under_voltage_in), .level(uv_lvl));

    pa_boost_pkg::fault_in_t flt;
    assign flt = '{over_current: oc_lvl, short_circuit: sc_lvl, over_voltage: ov_lvl, under_voltage: uv_lvl};

    // ---------------------------------
    // Control register
    // ---------------------------------
    pa_boost_pkg::control_reg_t ctrl_q;
    pa_boost_pkg::control_reg_t ctrl_d;
    logic exit_prev_q;
    logic exit_prev_d;
    logic host_write;
    logic exit_rise;
    logic [2:0] copy_val;

    assign host_write = reg_wr && (reg_addr == `PA_BOOST_CONTROL_ADDR);
    assign exit_rise = exit_lvl && !exit_prev_q;
    assign copy_val = ctrl_q.standby_exit_state_field;

    always_comb
    begin
        ctrl_d = ctrl_q;
        exit_prev_d = exit_lvl;
        if (host_write)
        begin
            ctrl_d = pa_boost_pkg::control_reg_t'(reg_wdata);
        end
        else if (exit_rise && copy_val[2])
        begin
            ctrl_d.output_state_field = copy_val;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_q <= pa_boost_pkg::control_reg_t'(`PA_BOOST_CONTROL_RESET);
            exit_prev_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            exit_prev_q <= exit_prev_d;
        end
    end

    // Only value 7 runs the regulator; other codes hold it off
    logic want_on;
    assign want_on = (ctrl_q.output_state_field == `STATE_ON);

    // ---------------------------------
    // Regulator sequencer
    // ---------------------------------
    pa_boost_pkg::reg_state_t st_q;
    pa_boost_pkg::reg_state_t st_d;
    logic [23:0] ss_cnt_q;
    logic [23:0] ss_cnt_d;
    logic on_prev_q;
    logic enable_edge;

    assign enable_edge = want_on && !on_prev_q;

    always_comb
    begin
        st_d = st_q;
        ss_cnt_d = ss_cnt_q;
        unique case (st_q)
            pa_boost_pkg::REG_OFF:
            begin
                ss_cnt_d = 24'h000000;
                if (enable_edge)
                begin
                    st_d = pa_boost_pkg::REG_SOFT_START;
                end
            end
            pa_boost_pkg::REG_SOFT_START:
            begin
                ss_cnt_d = ss_cnt_q + 24'h000001;
                if (!want_on)
                begin
                    st_d = pa_boost_pkg::REG_OFF;
                end
                else if (flt.over_voltage)
                begin
                    st_d = pa_boost_pkg::REG_LATCHED;
                end
                else if (ss_cnt_q == SS_LAST)
                begin
                    st_d = pa_boost_pkg::REG_RUN;
                end
            end
            pa_boost_pkg::REG_RUN:
            begin
                if (!want_on)
                begin
                    st_d = pa_boost_pkg::REG_OFF;
                end
                else if (flt.short_circuit || flt.over_voltage)
                begin
                    st_d = pa_boost_pkg::REG_LATCHED;
                end
            end
            pa_boost_pkg::REG_LATCHED:
            begin
                if (enable_edge)
                begin
                    st_d = pa_boost_pkg::REG_SOFT_START;
                end
                ss_cnt_d = 24'h000000;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_q <= pa_boost_pkg::REG_OFF;
            ss_cnt_q <= 24'h000000;
            on_prev_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ss_cnt_q <= ss_cnt_d;
            on_prev_q <= want_on;
        end
    end

    // ---------------------------------
    // Outputs
    // ---------------------------------
    logic running_d;
    logic fault_d;
    logic [7:0] rdata_d;
    always_comb
    begin
        running_d = (st_d == pa_boost_pkg::REG_SOFT_START) || (st_d == pa_boost_pkg::REG_RUN);
        // Flag held through ramp and latched shutdown; over-current and under-voltage flags clear when the fault goes
        fault_d = (st_d == pa_boost_pkg::REG_LATCHED) || (st_d == pa_boost_pkg::REG_SOFT_START)
            || (running_d && (flt.over_current || flt.under_voltage));
        rdata_d = (reg_addr == `PA_BOOST_CONTROL_ADDR) ? ctrl_d : 8'h00;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            regulator_enable <= 1'b0;
            switch_gate_enable <= 1'b0;
            isolation_switch <= 1'b0;
            boost_fault_flag <= 1'b0;
            select_5v0 <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            regulator_enable <= running_d;
            switch_gate_enable <= running_d && !flt.over_current;
            isolation_switch <= running_d;
            boost_fault_flag <= fault_d;
            select_5v0 <= (ctrl_d.output_voltage_select == `VSEL_5V0);
            reg_rdata <= rdata_d;
        end
    end

    // ---------------------------------
    // Checks
    // ---------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_short_latch: assert property ((st_q == pa_boost_pkg::REG_RUN && want_on && flt.short_circuit)
        |=> ##1 (!regulator_enable && !isolation_switch && boost_fault_flag)) else $error("short not latched");
    chk_latch_hold: assert property ((st_q == pa_boost_pkg::REG_LATCHED && !enable_edge)
        |=> st_q == pa_boost_pkg::REG_LATCHED) else $error("latched shutdown released");
    chk_ss_mask: assert property ((st_q == pa_boost_pkg::REG_SOFT_START && want_on && !flt.over_voltage)
        |=> st_q != pa_boost_pkg::REG_LATCHED) else $error("short seen in soft start");
    chk_ss_end: assert property ((st_q == pa_boost_pkg::REG_SOFT_START && ss_cnt_q == SS_LAST && want_on
        && !flt.over_voltage) |=> st_q == pa_boost_pkg::REG_RUN) else $error("soft start length wrong");
    chk_ov_latch: assert property ((st_q == pa_boost_pkg::REG_RUN && want_on && flt.over_voltage)
        |=> st_q == pa_boost_pkg::REG_LATCHED) else $error("overvoltage not latched");
    chk_flag_ramp: assert property ((st_q == pa_boost_pkg::REG_SOFT_START) |-> boost_fault_flag)
        else $error("flag low during ramp");
    chk_oc_gate: assert property ((running_d && flt.over_current) |=> (!switch_gate_enable && boost_fault_flag))
        else $error("overcurrent gate on");
    chk_oc_recover: assert property ((st_d == pa_boost_pkg::REG_RUN && !flt.over_current && !flt.under_voltage)
        |=> !boost_fault_flag) else $error("flag not cleared");
    chk_exit_copy: assert property ((!host_write && exit_rise && copy_val[2])
        |=> ctrl_q.output_state_field == $past(copy_val)) else $error("exit copy missing");
    chk_state_decode: assert property (regulator_enable |-> $past(ctrl_q.output_state_field) == `STATE_ON)
        else $error("runs without on code");
    chk_vsel_decode: assert property (select_5v0 |-> ctrl_q.output_voltage_select == `VSEL_5V0)
        else $error("select decode wrong");
endmodule
`default_nettype wire

/* design/pa_boost_defs.svh */
// Offsets, field positions, reset values and timing counts of the boost control block
`ifndef PA_BOOST_DEFS_SVH
`define PA_BOOST_DEFS_SVH
`define PA_BOOST_CONTROL_ADDR 8'h3B
`define PA_BOOST_CONTROL_RESET 8'h24
`define STATE_LSB 0
`define STATE_MSB 2
`define EXIT_LSB 3
`define EXIT_MSB 5
`define VSEL_LSB 6
`define VSEL_MSB 7
`define STATE_OFF 3'h4
`define STATE_ON 3'h7
`define VSEL_4V2 2'h0
`define VSEL_5V0 2'h2
`define CLK_HZ 25000000
`define SOFT_START_US 4000
`define SOFT_START_CYCLES ((`SOFT_START_US * (`CLK_HZ / 1000000)))
`endif

/* design/pa_boost_pkg.sv */
// Types shared by the boost control block
package pa_boost_pkg;
    typedef struct packed {
        logic [1:0] output_voltage_select;
        logic [2:0] standby_exit_state_field;
        logic [2:0] output_state_field;
    } control_reg_t;
    typedef struct packed {
        logic over_current;
        logic short_circuit;
        logic over_voltage;
        logic under_voltage;
    } fault_in_t;
    typedef enum logic [1:0] {
        REG_OFF,
        REG_SOFT_START,
        REG_RUN,
        REG_LATCHED
    } reg_state_t;
endpackage

/* design/pin_sync.sv */
// Three-flop synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;

    always_comb
    begin
        sync_d = {sync_q[1:0], pin};
        level_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : level_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench of the amplifier boost control block
`include "pa_boost_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int SS = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = `PA_BOOST_CONTROL_ADDR;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic exit_pin = 1'b0;
    logic oc = 1'b0, sc = 1'b0, ov = 1'b0, uv = 1'b0;
    logic [7:0] reg_rdata;
    logic en, gate, iso, flag, sel5;
    int err_total = 0;
    int n_checks = 0;
    int seed = 65984;
    logic [12:0] exp_q[$];

    always #20 clk_sys = ~clk_sys;

    pa_boost_fault_and_control #(.SOFT_START_CYCLES(SS)) pa_boost_fault_and_control_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .standby_exit_pin(exit_pin),
        .over_current_in(oc), .short_circuit_in(sc), .over_voltage_in(ov),
        .under_voltage_in(uv), .regulator_enable(en), .switch_gate_enable(gate),
        .isolation_switch(iso), .boost_fault_flag(flag), .select_5v0(sel5)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Outputs noted as enable, gate, isolation, flag, select
    task automatic note(input int n, input logic [7:0] rd, input logic [4:0] o);
        repeat (n) @(negedge clk_sys);
        exp_q.push_back({rd, o});
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic pulse_exit();
        exit_pin = 1'b1;
        tick(6);
        exit_pin = 1'b0;
        tick(6);
    endtask

    task automatic finish_test();
        tick(2);
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(negedge clk_sys)
    begin
        #5;
        while (exp_q.size() > 0)
            check({reg_rdata, en, gate, iso, flag, sel5}, exp_q.pop_front());
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        tick(20);
        rst_n = 1'b1;
        note(2, 8'h24, 5'b00000);
        reg_addr = 8'h3B ^ (8'h01 | 8'($random(seed)));
        wr(8'($random(seed)));
        note(2, 8'h00, 5'b00000);
        reg_addr = `PA_BOOST_CONTROL_ADDR;
        note(2, 8'h24, 5'b00000);
        $display("test reset_map done");
        for (int s = 0; s < 8; s++)
        begin
            wr({5'b00100, 3'(s)});
            note(3, {5'b00100, 3'(s)}, (s == 7) ? 5'b11110 : 5'b00000);
        end
        for (int v = 0; v < 4; v++)
        begin
            wr({2'(v), 6'h24});
            note(3, {2'(v), 6'h24}, {4'b0000, v == 2});
        end
        $display("test field_codes done");
        wr(8'h27);
        note(5, 8'h27, 5'b11110);
        note(SS + 10, 8'h27, 5'b11100);
        oc = 1'b1;
        note(8, 8'h27, 5'b10110);
        oc = 1'b0;
        note(8, 8'h27, 5'b11100);
        uv = 1'b1;
        note(8, 8'h27, 5'b11110);
        uv = 1'b0;
        note(8, 8'h27, 5'b11100);
        ov = 1'b1;
        note(8, 8'h27, 5'b00010);
        ov = 1'b0;
        note(8, 8'h27, 5'b00010);
        wr(8'h27);
        note(4, 8'h27, 5'b00010);
        wr(8'h24);
        sc = 1'b1;
        wr(8'h27);
        note(8, 8'h27, 5'b11110);
        note(SS + 4, 8'h27, 5'b00010);
        sc = 1'b0;
        note(8, 8'h27, 5'b00010);
        wr(8'h24);
        wr(8'h27);
        note(4, 8'h27, 5'b11110);
        note(SS + 10, 8'h27, 5'b11100);
        $display("test faults done");
        wr(8'h3C);
        note(3, 8'h3C, 5'b00000);
        pulse_exit();
        note(0, 8'h3F, 5'b11110);
        wr(8'h14);
        pulse_exit();
        note(0, 8'h14, 5'b00000);
        $display("test standby_exit done");
        finish_test();
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial
    begin
        #(4000 * 40);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
